// *** rtl/frls_top.sv ***
// read latency selector: maps read kind and latency code to cycles
// assumes requests come from logic on clk_sys, answers drained by it
`timescale 1ns/1ps
`default_nettype none
`include "frls_cfg.svh"
module frls_top #(
   parameter int DEPTH = `FRLS_FIFO_DEPTH
) (
   input  wire logic          clk_sys,  // 125 MHz system clock
   input  wire logic          rst_b,    // async reset, low
   input  wire logic          req_vld,  // lookup request offered
   output logic               req_rdy,  // request accepted
   input  wire frls_pkg::frls_req_s req, // read kind and setting
   output logic               ans_vld,  // answer available
   input  wire logic          ans_rdy,  // answer taken
   output frls_pkg::frls_ans_s ans      // mode and dummy counts
);
   import frls_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_PUSH = 2'b10
   } frls_st_e;

   frls_st_e  st_ff, nxt_st;
   frls_ans_s res_ff, nxt_res;
   logic      rdy_ff, nxt_rdy;
   logic      f_rdy;

   // ----------------------------------------------------------------
   // latency lookup
   // ----------------------------------------------------------------
   // one function so the table lives in a single place
   function automatic frls_ans_s lookup(input frls_req_s r);
      frls_ans_s a;
      a.mode_cyc  = `FRLS_CYC_NONE;
      a.dummy_cyc = `FRLS_CYC_NONE;
      a.unsup     = 1'b0;
      if (r.fast_row) begin
         // only fast read survives the top row
         if (r.cmd == FRLS_FAST && r.lat_code == `FRLS_LC_10) begin
            a.dummy_cyc = `FRLS_CYC_DUMMY8;        // see RL6
         end else begin
            a.mode_cyc  = `FRLS_CYC_UNSUP;         // see RL6
            a.dummy_cyc = `FRLS_CYC_UNSUP;
            a.unsup     = 1'b1;
         end
      end else begin
         case (r.cmd)
            FRLS_RD: begin
               // plain read only at the slowest code
               if (r.lat_code != `FRLS_LC_11) begin
                  a.mode_cyc  = `FRLS_CYC_UNSUP;   // see RL7
                  a.dummy_cyc = `FRLS_CYC_UNSUP;
                  a.unsup     = 1'b1;
               end                                 // see RL1
            end
            FRLS_FAST, FRLS_DOUT, FRLS_QOUT: begin
               if (r.lat_code != `FRLS_LC_11) begin
                  a.dummy_cyc = `FRLS_CYC_DUMMY8;  // see RL8
               end                                 // see RL1, RL2
            end
            FRLS_DIO: begin
               a.mode_cyc = `FRLS_DIO_MODE;        // see RL9
               case (r.lat_code)
                  `FRLS_LC_01: a.dummy_cyc = `FRLS_DIO_D_LC01; // see RL10
                  `FRLS_LC_10: a.dummy_cyc = `FRLS_DIO_D_LC10; // see RL10
                  default:     a.dummy_cyc = `FRLS_CYC_NONE;   // see RL10
               endcase
            end
            FRLS_QIO: begin
               a.mode_cyc = `FRLS_QIO_MODE;        // see RL11
               case (r.lat_code)
                  `FRLS_LC_11: a.dummy_cyc = `FRLS_QIO_D_LC11; // see RL12
                  `FRLS_LC_10: a.dummy_cyc = `FRLS_QIO_D_LC10; // see RL12
                  default:     a.dummy_cyc = `FRLS_QIO_D_LC0X; // see RL12
               endcase
            end
            default: begin
               a.mode_cyc  = `FRLS_CYC_UNSUP;
               a.dummy_cyc = `FRLS_CYC_UNSUP;
               a.unsup     = 1'b1;
            end
         endcase
      end
      // codes 11b/00b/01b/10b cover 50/80/90/104 MHz rows
      return a;                                    // see RL3, RL4, RL5
   endfunction

   // ----------------------------------------------------------------
   // take a request, then push its answer into the fifo
   // ----------------------------------------------------------------
   // one request in flight; trades rate for a registered req_rdy
   always_comb begin
      nxt_st  = st_ff;
      nxt_res = res_ff;
      nxt_rdy = rdy_ff;
      case (st_ff)
         ST_IDLE: begin
            if (req_vld && rdy_ff) begin
               nxt_res = lookup(req);
               nxt_st  = ST_PUSH;
               nxt_rdy = 1'b0;
            end else begin
               nxt_rdy = 1'b1;
            end
         end
         ST_PUSH: begin
            if (f_rdy) begin
               nxt_st  = ST_IDLE;
               nxt_rdy = 1'b1;
            end
         end
         default: begin
            nxt_st  = ST_IDLE;
            nxt_rdy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_ff  <= ST_IDLE;
         res_ff <= '0;
         rdy_ff <= 1'b0;
      end else begin
         st_ff  <= nxt_st;
         res_ff <= nxt_res;
         rdy_ff <= nxt_rdy;
      end
   end

   assign req_rdy = rdy_ff;

   // ----------------------------------------------------------------
   // answer buffer
   // ----------------------------------------------------------------
   // a stalled drain fills it, then the state machine holds in push
   frls_fifo #(
      .W ($bits(frls_ans_s)),
      .D (DEPTH)
   ) u_fifo (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .in_vld  (st_ff == ST_PUSH),
      .in_rdy  (f_rdy),
      .in_dat  (res_ff),
      .out_vld (ans_vld),
      .out_rdy (ans_rdy),
      .out_dat (ans)
   );
endmodule
`default_nettype wire

// *** shared/frls_cfg.svh ***
// constants for the read latency selector: codes, cycle counts, limits
// assumes the includer wants plain `define macros, guarded once
// Contract
// RL1: code 11b up to 50 MHz, read/fast zero
// RL2: code 11b dual/quad out zero cycles
// RL3: code 00b valid up to 80 MHz
// RL4: code 01b valid up to 90 MHz
// RL5: code 10b valid up to 104 MHz
// RL6: above 104 MHz only fast read, 8 dummies
// RL7: host avoids plain read above 50 MHz
// RL8: codes 00b/01b/10b fast/dual/quad out 8 dummies
// RL9: dual io always 4 mode cycles
// RL10: dual io dummies 0,0,1,2 by code
// RL11: quad io always 2 mode cycles
// RL12: quad io dummies 1,4,4,5 by code
// RL13: host picks code, counts cycles before sampling
`ifndef FRLS_CFG_SVH
`define FRLS_CFG_SVH
// ----------------------------------------------------------------
// latency codes and frequency limits
// ----------------------------------------------------------------
`define FRLS_LC_00        2'b00
`define FRLS_LC_01        2'b01
`define FRLS_LC_10        2'b10
`define FRLS_LC_11        2'b11
`define FRLS_LIM_LC11_MHZ 8'h32
`define FRLS_LIM_LC00_MHZ 8'h50
`define FRLS_LIM_LC01_MHZ 8'h5A
`define FRLS_LIM_LC10_MHZ 8'h68
`define FRLS_LIM_FAST_MHZ 8'h85
// ----------------------------------------------------------------
// cycle counts and fifo depth; ff marks a command unsupported at that rate
// ----------------------------------------------------------------
`define FRLS_CYC_NONE     8'h00
`define FRLS_CYC_UNSUP    8'hFF
`define FRLS_CYC_DUMMY8   8'h08
`define FRLS_DIO_MODE     8'h04
`define FRLS_QIO_MODE     8'h02
`define FRLS_DIO_D_LC01   8'h01
`define FRLS_DIO_D_LC10   8'h02
`define FRLS_QIO_D_LC11   8'h01
`define FRLS_QIO_D_LC0X   8'h04
`define FRLS_QIO_D_LC10   8'h05
`define FRLS_FIFO_DEPTH   8
`endif

// *** shared/frls_pkg.sv ***
// types for the read latency selector
// assumes frls_cfg.svh is compiled alongside
`default_nettype none
package frls_pkg;
   // ----------------------------------------------------------------
   // read command kinds
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FRLS_RD    = 3'h0,
      FRLS_FAST  = 3'h1,
      FRLS_DOUT  = 3'h2,
      FRLS_QOUT  = 3'h3,
      FRLS_DIO   = 3'h4,
      FRLS_QIO   = 3'h5
   } frls_cmd_e;

   typedef struct packed {
      frls_cmd_e   cmd;       // read kind
      logic [1:0]  lat_code;  // configured latency code
      logic        fast_row;  // serial clock above 104 MHz
   } frls_req_s;

   typedef struct packed {
      logic [7:0]  mode_cyc;  // mode cycles, ff if unsupported
      logic [7:0]  dummy_cyc; // dummy cycles, ff if unsupported
      logic        unsup;     // command not allowed at this setting
   } frls_ans_s;
endpackage
`default_nettype wire

// *** rtl/frls_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes one clock, reset asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module frls_fifo #(
   parameter int W = 17,
   parameter int D = 8
) (
   input  wire logic         clk_sys, // system clock
   input  wire logic         rst_b,   // async reset, low
   input  wire logic         in_vld,  // write offered
   output logic              in_rdy,  // room for a word
   input  wire logic [W-1:0] in_dat,  // write data
   output logic              out_vld, // word available
   input  wire logic         out_rdy, // drain accepts
   output logic [W-1:0]      out_dat  // read data, registered
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_ff [D];
   logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [AW:0]   cnt_ff, nxt_cnt;
   logic [W-1:0]  head_ff, nxt_head;
   logic          vld_ff, nxt_vld;
   logic          wr, rd;

   // ----------------------------------------------------------------
   // pointer and count update
   // ----------------------------------------------------------------
   // head word kept in out_dat so the read side sees a flop
   always_comb begin
      wr      = in_vld && in_rdy;
      rd      = out_vld && out_rdy;
      nxt_wp  = wr ? AW'(wp_ff + 1'b1) : wp_ff;
      nxt_rp  = rd ? AW'(rp_ff + 1'b1) : rp_ff;
      nxt_cnt = (AW+1)'(cnt_ff + wr - rd);
      nxt_vld = (nxt_cnt != '0);
      // a word written into the slot about to become head goes straight to the head as it is stored
      nxt_head = (wr && (wp_ff == nxt_rp)) ? in_dat : mem_ff[nxt_rp];
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
         head_ff <= '0;
         vld_ff <= 1'b0;
      end else begin
         wp_ff  <= nxt_wp;
         rp_ff  <= nxt_rp;
         cnt_ff <= nxt_cnt;
         head_ff <= nxt_head;
         vld_ff <= nxt_vld;
      end
   end

   // storage has no reset; only written words are ever read
   always_ff @(posedge clk_sys) begin
      if (wr) begin
         mem_ff[wp_ff] <= in_dat;
      end
   end

   assign in_rdy  = (cnt_ff != (AW+1)'(D));
   // both read-side outputs are flops, same timing as the count
   assign out_vld = vld_ff;
   assign out_dat = head_ff;
endmodule
`default_nettype wire

// *** dv/frls_top_asserts.sv ***
// checker for the read latency selector, bound to frls_top
// assumes a lookup into an empty fifo shows at the head two edges later
`timescale 1ns/1ps
`default_nettype none
module frls_top_asserts (
   input wire logic               clk_sys, // clock
   input wire logic               rst_b,   // reset, low
   input wire logic               req_vld, // offer
   input wire logic               req_rdy, // accept
   input wire frls_pkg::frls_req_s req,    // request
   input wire logic               ans_vld, // answer valid
   input wire logic               ans_rdy, // answer taken
   input wire frls_pkg::frls_ans_s ans     // answer
);
   import frls_pkg::*;
   logic      tk1_ff, tk2_ff; // lone take, delayed
   frls_req_s rq_ff;          // request of the last take
   wire tk = req_vld && req_rdy;
   // only lone lookups are judged: a busy fifo hides which word is new
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tk1_ff <= 1'b0;
         tk2_ff <= 1'b0;
         rq_ff  <= '0;
      end else begin
         tk1_ff <= tk && !ans_vld;
         tk2_ff <= tk1_ff;
         if (tk) rq_ff <= req;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_take_drops: assert property (tk |=> !req_rdy)
      else $error("ready stayed up after a take");
   a_ans_timely: assert property (tk2_ff |-> ans_vld)
      else $error("answer late");
   a_head_holds: assert property (ans_vld && !ans_rdy |=> ans_vld && $stable(ans))
      else $error("head word changed before it was taken");
   a_fast_only: assert property (tk2_ff && rq_ff.fast_row |->
      ans.unsup == !(rq_ff.cmd == FRLS_FAST && rq_ff.lat_code == 2'b10)
      && (ans.unsup || ans.dummy_cyc == 8'h08))
      else $error("fast row answer wrong");
   a_slow_zero: assert property (tk2_ff && !rq_ff.fast_row
      && rq_ff.lat_code == 2'b11 && rq_ff.cmd inside {FRLS_RD, FRLS_FAST,
      FRLS_DOUT, FRLS_QOUT} |-> ans == 17'h0)
      else $error("code 11b answer not zero");
   a_eight_dummy: assert property (tk2_ff && !rq_ff.fast_row
      && rq_ff.lat_code != 2'b11 && rq_ff.cmd inside {FRLS_FAST, FRLS_DOUT,
      FRLS_QOUT} |-> ans == {8'h00, 8'h08, 1'b0})
      else $error("eight dummy cycles missing");
   a_plain_unsup: assert property (tk2_ff && !rq_ff.fast_row
      && rq_ff.cmd == FRLS_RD && rq_ff.lat_code != 2'b11 |-> ans == 17'h1_FFFF)
      else $error("plain read not refused");
   a_dual_io: assert property (tk2_ff && !rq_ff.fast_row
      && rq_ff.cmd == FRLS_DIO |-> ans.mode_cyc == 8'h04 && ans.dummy_cyc ==
      (rq_ff.lat_code == 2'b10 ? 8'h02 : rq_ff.lat_code == 2'b01 ? 8'h01 : 8'h00))
      else $error("dual io counts wrong");
   a_quad_io: assert property (tk2_ff && !rq_ff.fast_row
      && rq_ff.cmd == FRLS_QIO |-> ans.mode_cyc == 8'h02 && ans.dummy_cyc ==
      (rq_ff.lat_code == 2'b11 ? 8'h01 : rq_ff.lat_code == 2'b10 ? 8'h05 : 8'h04))
      else $error("quad io counts wrong");
endmodule
bind frls_top frls_top_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .req_vld(req_vld), .req_rdy(req_rdy), .req(req), .ans_vld(ans_vld),
   .ans_rdy(ans_rdy), .ans(ans));
`default_nettype wire

// *** dv/frls_host_model.sv ***
// host model: takes latency answers off the selector's fifo
// assumes the bench sets stall and slow between scenarios
`timescale 1ns/1ps
`default_nettype none
module frls_host_model (
   input wire logic clk_sys, // clock
   input wire logic rst_b,   // reset, low
   input wire logic stall,   // hold off all answers
   input wire logic slow,    // take every other cycle
   output logic     ans_rdy  // drain accepts
);
   logic rdy_ff, nxt_rdy;
   assign ans_rdy = rdy_ff;
   // the host needs one answer per read before it counts cycles;
   // stalling it is how the fifo gets filled
   always_comb nxt_rdy = !stall && !(slow && rdy_ff);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) rdy_ff <= 1'b0;
      else rdy_ff <= nxt_rdy;
   end
endmodule
`default_nettype wire

// *** dv/frls_top_test.sv ***
// bench for the read latency selector with a host draining answers
// assumes the checker is bound in and the fifo holds 8 words
`timescale 1ns/1ps
`default_nettype none
module frls_top_test;
   import frls_pkg::*;
   logic      clk_sys = 1'b0;
   logic      rst_b = 1'b0;
   logic      req_vld = 1'b0;
   logic      stall = 1'b0;
   logic      slow = 1'b0;
   logic      req_rdy, ans_vld, ans_rdy;
   frls_req_s req = '0;
   frls_ans_s ans;
   frls_ans_s exp_q[$], got_q[$];
   int        n_mismatch = 0;
   int        checks_done = 0;
   always #4 clk_sys = ~clk_sys;
   frls_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .req_vld(req_vld),
      .req_rdy(req_rdy), .req(req), .ans_vld(ans_vld), .ans_rdy(ans_rdy),
      .ans(ans));
   frls_host_model u_host (.clk_sys(clk_sys), .rst_b(rst_b), .stall(stall),
      .slow(slow), .ans_rdy(ans_rdy));
   // every word the host takes, in order
   always @(posedge clk_sys) begin
      if (ans_vld === 1'b1 && ans_rdy === 1'b1) got_q.push_back(ans);
   end
   task automatic chk(input logic [16:0] seen, input logic [16:0] want);
      checks_done++;
      if (seen !== want) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   // expected counts; unsupported is ff, ff and the flag
   function automatic frls_ans_s lut(input logic [2:0] c,
      input logic [1:0] l, input logic f);
      frls_ans_s u;
      u = 17'h1_FFFF;
      if (f) return (c == 3'h1 && l == 2'b10) ? {8'h00, 8'h08, 1'b0} : u;
      case (c)
         3'h0: return (l == 2'b11) ? 17'h0 : u;
         3'h1, 3'h2, 3'h3: return (l == 2'b11) ? 17'h0 : {8'h00, 8'h08, 1'b0};
         3'h4: return {8'h04, (l == 2'b10) ? 8'h02 : {7'h00, l == 2'b01}, 1'b0};
         3'h5: return {8'h02, (l == 2'b11) ? 8'h01 :
            (l == 2'b10) ? 8'h05 : 8'h04, 1'b0};
         default: return u;
      endcase
   endfunction
   task automatic send(input logic [2:0] c, input logic [1:0] l, input logic f);
      int i;
      @(posedge clk_sys);
      req_vld <= 1'b1;
      req <= {frls_cmd_e'(c), l, f};
      exp_q.push_back(lut(c, l, f));
      for (i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         if (req_rdy === 1'b1) break;
      end
      req_vld <= 1'b0;
      chk(17'(i < 40), 17'h1);
   endtask
   task automatic drain();
      for (int i = 0; i < 400 && got_q.size() < exp_q.size(); i++) begin
         @(posedge clk_sys);
      end
      chk(17'(got_q.size()), 17'(exp_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0) begin
         chk(got_q.pop_front(), exp_q.pop_front());
      end
      exp_q.delete();
      got_q.delete();
   endtask
   // every kind, code and row, each alone so the checker judges it too
   task automatic t_table();
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 8; k++) begin
            send(3'(c), 2'(k >> 1), 1'(k));
            drain();
         end
      end
   endtask
   // host stalls: 8 words fill the fifo, one waits, the next is refused
   task automatic t_fill();
      stall <= 1'b1;
      for (int i = 0; i < 9; i++) send(3'(i % 6), 2'(i), 1'b0);
      @(posedge clk_sys);
      req_vld <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(17'(req_rdy), 17'h0);
      req_vld <= 1'b0;
      stall <= 1'b0;
      slow <= 1'b1;
      drain();
      @(posedge clk_sys);
      chk(17'(ans_vld), 17'h0);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_table();
      t_fill();
      wrap_up();
   end
   // a hang costs a mismatch; the run needs well under 2000 cycles
   initial begin
      #100_000;
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
